/* verilog/pise_irq_status.sv */
// Purpose: Interrupt status and enable registers with the interrupt pin
// Assumes: Event inputs are one-cycle pulses on i_clk; pin input is async
// Notes: Read data appears one cycle after the read strobe
//
// Operation
// - Link quality change while link is up sets first bit 15, enable 7.
// - Energy detect change sets first bit 14, gated by enable 6.
// - Link status change sets first bit 13, gated by enable 5.
// - Speed change sets first bit 12, gated by enable 4.
// - Duplex change sets first bit 11, gated by enable 3.
// - Auto-negotiation completion sets first bit 10, gated by enable 2.
// - False-carrier tally passing half full sets first bit 9, enable 1.
// - Receive-fault tally passing half full sets first bit 8, enable 0.
// - Energy-efficient Ethernet error sets second bit 15, gated by enable 7.
// - Auto-negotiation error sets second bit 14, gated by enable 6.
// - Page received sets second bit 13, gated by enable 5.
// - Loopback FIFO overflow or underflow sets second bit 12, enable 4.
// - Crossover change sets second bit 11, gated by enable 3.
// - Sleep mode event sets second bit 10, gated by enable 2.
// - Inverted polarity or wake-up packet sets shared second bit 9, enable 1.
// - Jabber detection sets second bit 8, gated by enable 0.
// - All flags and enables of both registers reset to zero.
// - Event interrupts reach the pin only with the global enable set.
// - Pin drives interrupt only when output enable is 1, else power-down input.
// - Polarity 0 idles low active high; 1 idles high active low.
// - Test bit forces an interrupt for as long as it is set.
`timescale 1ns/1ps
module pise_irq_status (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [4:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire logic i_link_up,
  input wire logic i_link_quality_change,
  input wire logic i_energy_change,
  input wire logic i_link_status_change,
  input wire logic i_speed_change,
  input wire logic i_duplex_change,
  input wire logic i_an_complete,
  input wire logic [7:0] i_false_carrier_tally,
  input wire logic [15:0] i_receive_fault_tally,
  input wire logic i_eee_error,
  input wire logic i_an_error,
  input wire logic i_page_received,
  input wire logic i_lb_fifo_error,
  input wire logic i_crossover_change,
  input wire logic i_sleep_event,
  input wire logic i_polarity_inverted,
  input wire logic i_wol_packet,
  input wire logic i_jabber,
  input wire logic i_global_irq_en,
  input wire logic i_test_irq,
  input wire logic i_irq_polarity,
  input wire logic i_irq_out_en,
  input wire logic i_irq_or_powerdown_pin_in,
  output logic o_irq_or_powerdown_pin_out,
  output logic o_irq_or_powerdown_pin_oe,
  output logic o_irq_request,
  output logic o_powerdown
);

  typedef struct packed {
    logic pin_meta;
    logic pin_sync;
    logic fc_above;
    logic rf_above;
    logic [15:0] rdata;
    logic rvalid;
    logic irq_req;
    logic pin_out;
    logic pin_oe;
    logic powerdown;
  } pise_top_type;

  pise_top_type state_r;
  pise_top_type state_nxt;

  logic [7:0] set_first;
  logic [7:0] set_second;
  logic [15:0] first_word;
  logic [15:0] second_word;
  logic first_pending;
  logic second_pending;
  logic rd_first;
  logic rd_second;
  logic wr_first;
  logic wr_second;
  logic fc_cmp;
  logic rf_cmp;

  function automatic logic addr_is(input logic [4:0] addr, input logic [4:0] target);
    addr_is = (addr == target);
  endfunction

  // Address decode
  assign rd_first = i_reg_rd && addr_is(i_reg_addr, pise_pkg::ADDR_FIRST);
  assign rd_second = i_reg_rd && addr_is(i_reg_addr, pise_pkg::ADDR_SECOND);
  assign wr_first = i_reg_wr && addr_is(i_reg_addr, pise_pkg::ADDR_FIRST);
  assign wr_second = i_reg_wr && addr_is(i_reg_addr, pise_pkg::ADDR_SECOND);

  // Half-full threshold crossings
  assign fc_cmp = pise_pkg::pise_above_half({8'h00, i_false_carrier_tally});
  assign rf_cmp = pise_pkg::pise_above_half(i_receive_fault_tally);

  // Event sources of the first register
  always_comb begin
    set_first = 8'h00;
    set_first[pise_pkg::FIRST_LINK_QUALITY] = i_link_quality_change && i_link_up;
    set_first[pise_pkg::FIRST_ENERGY] = i_energy_change;
    set_first[pise_pkg::FIRST_LINK_STATUS] = i_link_status_change;
    set_first[pise_pkg::FIRST_SPEED] = i_speed_change;
    set_first[pise_pkg::FIRST_DUPLEX] = i_duplex_change;
    set_first[pise_pkg::FIRST_AN_DONE] = i_an_complete;
    set_first[pise_pkg::FIRST_FALSE_CARRIER_HF] = fc_cmp && !state_r.fc_above;
    set_first[pise_pkg::FIRST_RX_FAULT_HF] = rf_cmp && !state_r.rf_above;
  end

  // Event sources of the second register
  always_comb begin
    set_second = 8'h00;
    set_second[pise_pkg::SECOND_EEE_ERROR] = i_eee_error;
    set_second[pise_pkg::SECOND_AN_ERROR] = i_an_error;
    set_second[pise_pkg::SECOND_PAGE_RX] = i_page_received;
    set_second[pise_pkg::SECOND_LB_FIFO] = i_lb_fifo_error;
    set_second[pise_pkg::SECOND_CROSSOVER] = i_crossover_change;
    set_second[pise_pkg::SECOND_SLEEP] = i_sleep_event;
    set_second[pise_pkg::SECOND_POL_WOL] = i_polarity_inverted || i_wol_packet;
    set_second[pise_pkg::SECOND_JABBER] = i_jabber;
  end

  pise_evt_bank u_first (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_set(set_first),
    .i_wr(wr_first),
    .i_wdata(i_reg_wdata[7:0]),
    .i_rd_clr(rd_first),
    .o_word(first_word),
    .o_pending(first_pending)
  );

  pise_evt_bank u_second (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_set(set_second),
    .i_wr(wr_second),
    .i_wdata(i_reg_wdata[7:0]),
    .i_rd_clr(rd_second),
    .o_word(second_word),
    .o_pending(second_pending)
  );

  always_comb begin
    state_nxt = state_r;
    // Pin input synchroniser
    state_nxt.pin_meta = i_irq_or_powerdown_pin_in;
    state_nxt.pin_sync = state_r.pin_meta;
    state_nxt.fc_above = fc_cmp;
    state_nxt.rf_above = rf_cmp;
    // Read data, unmapped addresses read zero
    state_nxt.rvalid = i_reg_rd;
    if (rd_first) begin
      state_nxt.rdata = first_word;
    end else if (rd_second) begin
      state_nxt.rdata = second_word;
    end else if (i_reg_rd) begin
      state_nxt.rdata = pise_pkg::RDATA_RESET;
    end
    // Interrupt request
    state_nxt.irq_req = (i_global_irq_en && (first_pending || second_pending))
                        || i_test_irq;
    state_nxt.pin_out = state_nxt.irq_req ^ i_irq_polarity;
    state_nxt.pin_oe = i_irq_out_en;
    state_nxt.powerdown = !i_irq_out_en && !state_r.pin_sync;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_r.pin_meta <= 1'b1;
      state_r.pin_sync <= 1'b1;
      state_r.fc_above <= 1'b0;
      state_r.rf_above <= 1'b0;
      state_r.rdata <= pise_pkg::RDATA_RESET;
      state_r.rvalid <= 1'b0;
      state_r.irq_req <= 1'b0;
      state_r.pin_out <= pise_pkg::PIN_OUT_RESET;
      state_r.pin_oe <= 1'b0;
      state_r.powerdown <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign o_reg_rdata = state_r.rdata;
  assign o_reg_rvalid = state_r.rvalid;
  assign o_irq_request = state_r.irq_req;
  assign o_irq_or_powerdown_pin_out = state_r.pin_out;
  assign o_irq_or_powerdown_pin_oe = state_r.pin_oe;
  assign o_powerdown = state_r.powerdown;

  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  a_link_quality_set: assert property (
    i_link_quality_change && i_link_up |=> first_word[15])
    else $error("link quality flag not set");
  a_link_quality_down: assert property (
    !first_word[15] && i_link_quality_change && !i_link_up |=> !first_word[15])
    else $error("link quality flag set while link down");
  a_energy_set: assert property (
    i_energy_change |=> first_word[14])
    else $error("energy flag not set");
  a_link_status_set: assert property (
    i_link_status_change |=> first_word[13])
    else $error("link status flag not set");
  a_speed_set: assert property (
    i_speed_change |=> first_word[12])
    else $error("speed flag not set");
  a_duplex_set: assert property (
    i_duplex_change |=> first_word[11])
    else $error("duplex flag not set");
  a_an_done_set: assert property (
    i_an_complete |=> first_word[10])
    else $error("negotiation done flag not set");
  a_false_carrier_half: assert property (
    {8'h00, i_false_carrier_tally} > pise_pkg::HALF_FULL
    && {8'h00, $past(i_false_carrier_tally)} <= pise_pkg::HALF_FULL |=> first_word[9])
    else $error("false carrier half-full flag not set");
  a_rx_fault_half: assert property (
    i_receive_fault_tally > pise_pkg::HALF_FULL
    && $past(i_receive_fault_tally) <= pise_pkg::HALF_FULL |=> first_word[8])
    else $error("receive fault half-full flag not set");
  a_eee_error_set: assert property (
    i_eee_error |=> second_word[15])
    else $error("eee error flag not set");
  a_an_error_set: assert property (
    i_an_error |=> second_word[14])
    else $error("negotiation error flag not set");
  a_page_rx_set: assert property (
    i_page_received |=> second_word[13])
    else $error("page flag not set");
  a_lb_fifo_set: assert property (
    i_lb_fifo_error |=> second_word[12])
    else $error("loopback fifo flag not set");
  a_crossover_set: assert property (
    i_crossover_change |=> second_word[11])
    else $error("crossover flag not set");
  a_sleep_set: assert property (
    i_sleep_event |=> second_word[10])
    else $error("sleep flag not set");
  a_pol_wol_set: assert property (
    i_polarity_inverted || i_wol_packet |=> second_word[9])
    else $error("polarity or wake flag not set");
  a_jabber_set: assert property (
    i_jabber |=> second_word[8])
    else $error("jabber flag not set");
  a_reset_clear: assert property (
    @(posedge i_clk) disable iff (1'b0)
    $past(i_reset) |-> first_word == 16'h0000 && second_word == 16'h0000)
    else $error("registers not zero after reset");
  a_global_gate: assert property (
    !i_global_irq_en && !i_test_irq |=> !o_irq_request)
    else $error("request without global enable");
  a_pin_direction: assert property (
    $changed(i_irq_out_en) |=> o_irq_or_powerdown_pin_oe == $past(i_irq_out_en)
    && (!o_irq_or_powerdown_pin_oe || !o_powerdown))
    else $error("pin direction wrong");
  a_powerdown_off: assert property (
    i_irq_out_en |=> !o_powerdown)
    else $error("power-down while pin is output");
  a_pin_polarity: assert property (
    ##1 o_irq_or_powerdown_pin_out == ($past(i_irq_polarity) ^ o_irq_request))
    else $error("pin level does not follow polarity");
  a_test_force: assert property (
    i_test_irq [*2] |=> o_irq_request [*1])
    else $error("test interrupt not generated");
  a_read_clear: assert property (
    rd_first && set_first == 8'h00 |=> first_word[15:8] == 8'h00
    && o_reg_rvalid && o_reg_rdata == $past(first_word))
    else $error("read did not return and clear flags");
  a_set_over_clear: assert property (
    rd_second && i_jabber |=> second_word[8])
    else $error("event lost during clearing read");
  a_pending_request: assert property (
    i_global_irq_en && (first_pending || second_pending) |=> o_irq_request)
    else $error("enabled pending flag gave no request");
  a_no_pending_idle: assert property (
    !first_pending && !second_pending && !i_test_irq |=> !o_irq_request)
    else $error("request without enabled pending flag");

  a_reset_outputs: assert property (
    @(posedge i_clk) disable iff (1'b0)
    $past(i_reset) |-> !o_irq_request && !o_reg_rvalid && !o_powerdown
    && !o_irq_or_powerdown_pin_oe && o_irq_or_powerdown_pin_out)
    else $error("outputs not at reset values");
  a_rvalid_pulse: assert property (
    i_reg_rd |=> o_reg_rvalid)
    else $error("read gave no valid strobe");
  a_rvalid_quiet: assert property (
    !i_reg_rd |=> !o_reg_rvalid)
    else $error("valid strobe without read");
  a_unmapped_zero: assert property (
    i_reg_rd && i_reg_addr != pise_pkg::ADDR_FIRST && i_reg_addr != pise_pkg::ADDR_SECOND
    |=> o_reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_read_second: assert property (
    rd_second && set_second == 8'h00 |=> second_word[15:8] == 8'h00
    && o_reg_rdata == $past(second_word))
    else $error("second word read did not return and clear flags");
  a_flag_sticky: assert property (
    first_word[15] && !rd_first |=> first_word[15])
    else $error("first word flag lost without read");
  a_sticky_second: assert property (
    second_word[8] && !rd_second |=> second_word[8])
    else $error("second word flag lost without read");
  a_write_first: assert property (
    wr_first |=> first_word[7:0] == $past(i_reg_wdata[7:0]))
    else $error("first word enables not written");
  a_write_second: assert property (
    wr_second |=> second_word[7:0] == $past(i_reg_wdata[7:0]))
    else $error("second word enables not written");
  a_enables_hold: assert property (
    !i_reg_wr |=> $stable(first_word[7:0]) && $stable(second_word[7:0]))
    else $error("enables changed without write");
  a_fc_no_retrigger: assert property (
    !$past(i_reset) && !first_word[9]
    && {8'h00, i_false_carrier_tally} > pise_pkg::HALF_FULL
    && {8'h00, $past(i_false_carrier_tally)} > pise_pkg::HALF_FULL |=> !first_word[9])
    else $error("false carrier flag set again while above half");
  a_powerdown_low: assert property (
    !i_irq_out_en && !$past(i_irq_or_powerdown_pin_in, 2) && !$past(i_reset)
    && !$past(i_reset, 2) |=> o_powerdown)
    else $error("low pin gave no power-down");
  a_powerdown_high: assert property (
    $past(i_irq_or_powerdown_pin_in, 2) && !$past(i_reset) && !$past(i_reset, 2)
    |=> !o_powerdown)
    else $error("power-down with high pin");

  c_event_to_irq: cover property (
    i_link_status_change ##1 first_word[13] && first_word[5] ##2 o_irq_request);
  c_read_clear: cover property (rd_second && second_word[15:8] != 8'h00);
  c_test_irq: cover property (i_test_irq ##1 o_irq_request && !first_pending);
  c_powerdown: cover property (o_powerdown);

endmodule // pise_irq_status

/* verilog/pise_pkg.sv */
// Purpose: Shared constants and types of the event status and enable block
// Assumes: 16-bit management words, register addresses 5 bits wide
// Notes: Status flags sit in the upper byte, their enables in the lower byte
package pise_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int EVT_W = 8;

  // Register addresses
  localparam logic [4:0] ADDR_FIRST = 5'h12;
  localparam logic [4:0] ADDR_SECOND = 5'h13;

  // Field positions
  localparam int STATUS_LSB = 8;
  localparam int ENABLE_LSB = 0;

  // Event index inside each byte of the first register
  localparam int FIRST_LINK_QUALITY = 7;
  localparam int FIRST_ENERGY = 6;
  localparam int FIRST_LINK_STATUS = 5;
  localparam int FIRST_SPEED = 4;
  localparam int FIRST_DUPLEX = 3;
  localparam int FIRST_AN_DONE = 2;
  localparam int FIRST_FALSE_CARRIER_HF = 1;
  localparam int FIRST_RX_FAULT_HF = 0;

  // Event index inside each byte of the second register
  localparam int SECOND_EEE_ERROR = 7;
  localparam int SECOND_AN_ERROR = 6;
  localparam int SECOND_PAGE_RX = 5;
  localparam int SECOND_LB_FIFO = 4;
  localparam int SECOND_CROSSOVER = 3;
  localparam int SECOND_SLEEP = 2;
  localparam int SECOND_POL_WOL = 1;
  localparam int SECOND_JABBER = 0;

  // Reset values
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] ENABLES_RESET = 8'h00;
  localparam logic [15:0] RDATA_RESET = 16'h0000;
  localparam logic PIN_OUT_RESET = 1'b1;

  // Counter threshold for the half-full events
  localparam logic [15:0] HALF_FULL = 16'h007f;

  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] enables;
  } pise_bank_type;

  function automatic logic pise_above_half(input logic [15:0] value);
    pise_above_half = (value > HALF_FULL);
  endfunction

endpackage

/* verilog/pise_evt_bank.sv */
// Purpose: One 16-bit word of eight sticky event flags and eight enables
// Assumes: Set pulses come from logic on the same clock
// Notes: A set in the cycle of a clearing read keeps the flag set
`timescale 1ns/1ps
module pise_evt_bank (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_set,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic i_rd_clr,
  output logic [15:0] o_word,
  output logic o_pending
);

  pise_pkg::pise_bank_type state_r;
  pise_pkg::pise_bank_type state_nxt;

  always_comb begin
    state_nxt = state_r;
    // Flags latch regardless of enable; read clears, set wins
    state_nxt.flags = (state_r.flags & ~{8{i_rd_clr}}) | i_set;
    if (i_wr) begin
      state_nxt.enables = i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_r.flags <= pise_pkg::FLAGS_RESET;
      state_r.enables <= pise_pkg::ENABLES_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign o_word = {state_r.flags, state_r.enables};
  assign o_pending = |(state_r.flags & state_r.enables);

endmodule // pise_evt_bank

/* testbench/pise_host_model.sv */
// Purpose: Host side of the register port and of the shared interrupt pin
// Assumes: Requests start at a falling edge and are taken at the next rise
// Notes: Released bus lines show the inverse of their last value
`timescale 1ns/1ps
module pise_host_model (
  input wire logic i_clk,
  input wire logic i_pin_out,
  input wire logic i_pin_oe,
  output logic [4:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [15:0] o_wdata,
  output logic o_pin
);
  logic pd_level = 1'b1;

  // Wire level: device drive while enabled, else the host's own level
  assign o_pin = i_pin_oe ? i_pin_out : pd_level;

  initial begin
    o_addr = 5'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 16'h0000;
  end

  // One strobe cycle, held across the taking edge, then one idle cycle
  task automatic access(input logic wr, input logic [4:0] a, input logic [15:0] d);
    o_addr = a;
    o_wdata = d;
    o_wr = wr;
    o_rd = !wr;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
    @(negedge i_clk);
  endtask
endmodule // pise_host_model

/* testbench/phy_interrupt_status_enable_tb.sv */
// Purpose: Self-checking bench of the event status and enable block
// Assumes: Inputs change at the falling edge of the clock
// Notes: Expected read values are queued by the driver and checked by a monitor
`timescale 1ns/1ps
module phy_interrupt_status_enable_tb;
  logic i_clk, i_reset, link_up, glob, test, pol, out_en;
  logic wr, rd, rvalid, pin, pin_out, pin_oe, req, pwd;
  logic [16:0] ev;
  logic [7:0] fc_hi;
  logic [4:0] addr, a;
  logic [15:0] rf_hi, wdata, rdata, e, d;
  int fail_count = 0;
  int samples_checked = 0;
  int seed = 75344;
  int idx;
  logic [15:0] exp_q[$];

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  pise_irq_status dut (.i_clk(i_clk), .i_reset(i_reset), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_link_up(link_up), .i_link_quality_change(ev[7]), .i_energy_change(ev[6]),
    .i_link_status_change(ev[5]), .i_speed_change(ev[4]), .i_duplex_change(ev[3]),
    .i_an_complete(ev[2]), .i_false_carrier_tally(ev[1] ? fc_hi : 8'h00),
    .i_receive_fault_tally(ev[0] ? rf_hi : 16'h0000), .i_eee_error(ev[15]),
    .i_an_error(ev[14]), .i_page_received(ev[13]), .i_lb_fifo_error(ev[12]),
    .i_crossover_change(ev[11]), .i_sleep_event(ev[10]), .i_polarity_inverted(ev[9]),
    .i_wol_packet(ev[16]), .i_jabber(ev[8]), .i_global_irq_en(glob), .i_test_irq(test),
    .i_irq_polarity(pol), .i_irq_out_en(out_en), .i_irq_or_powerdown_pin_in(pin),
    .o_irq_or_powerdown_pin_out(pin_out), .o_irq_or_powerdown_pin_oe(pin_oe),
    .o_irq_request(req), .o_powerdown(pwd));

  pise_host_model host (.i_clk(i_clk), .i_pin_out(pin_out), .i_pin_oe(pin_oe), .o_addr(addr),
    .o_wr(wr), .o_rd(rd), .o_wdata(wdata), .o_pin(pin));

  task automatic chk(input string name, input logic [15:0] ex, input logic [15:0] g);
    samples_checked++;
    if (g !== ex) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, ex, g);
    end
  endtask

  task automatic rd_word(input logic [4:0] ra, input logic [15:0] ex);
    exp_q.push_back(ex);
    host.access(1'b0, ra, 16'h0000);
  endtask

  task automatic fire(input int i);
    ev[i] = 1'b1;
    @(negedge i_clk);
    ev = '0;
  endtask

  task automatic wait_req(input logic ex);
    int n;
    n = 0;
    while (req !== ex && n < 5) begin
      @(negedge i_clk);
      n++;
    end
    chk("request", ex, req);
    chk("pin drive", ex ^ pol, pin_out);
    chk("pin enable", 1'b1, pin_oe);
  endtask

  task automatic hold_low();
    repeat (4) @(negedge i_clk);
    chk("request held", 1'b0, req);
  endtask

  task automatic test_done();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Read monitor: each valid answer is matched with the oldest note
  always @(negedge i_clk) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected read", 16'h0000, 16'h0001);
      else chk("read data", exp_q.pop_front(), rdata);
    end
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    fail_count++;
    test_done();
  end

  initial begin
    i_reset = 1'b1;
    link_up = 1'b1;
    glob = 1'b0;
    test = 1'b0;
    pol = 1'b1;
    out_en = 1'b0;
    ev = '0;
    fc_hi = 8'h80;
    rf_hi = 16'h0080;
    repeat (6) @(negedge i_clk);
    i_reset = 1'b0;
    chk("idle pin", 1'b1, pin_out);
    chk("idle request", 1'b0, req);
    rd_word(5'h12, 16'h0000);
    rd_word(5'h13, 16'h0000);
    rd_word(5'h14, 16'h0000);
    for (int i = 0; i < 17; i++) begin
      idx = (i == 16) ? 9 : i;
      a = (idx < 8) ? 5'h12 : 5'h13;
      e = 16'h0100 << (idx % 8);
      fc_hi = 8'h80 | 8'($random(seed));
      rf_hi = 16'h0080 | 16'($random(seed));
      fire(i);
      rd_word(a, e);
      ev[i] = 1'b1;
      rd_word(a, 16'h0000);
      ev = '0;
      rd_word(a, e);
      rd_word(a, 16'h0000);
    end
    link_up = 1'b0;
    fire(7);
    rd_word(5'h12, 16'h0000);
    link_up = 1'b1;
    for (int r = 0; r < 2; r++) begin
      d = 16'($random(seed));
      host.access(1'b1, 5'h12 + 5'(r), d);
      rd_word(5'h12 + 5'(r), {8'h00, d[7:0]});
      host.access(1'b1, 5'h12 + 5'(r), 16'h0000);
    end
    glob = 1'b1;
    host.access(1'b1, 5'h12, 16'hffff);
    fire(5);
    repeat (3) @(negedge i_clk);
    chk("request before reset", 1'b1, req);
    i_reset = 1'b1;
    repeat (2) @(negedge i_clk);
    i_reset = 1'b0;
    chk("request after reset", 1'b0, req);
    chk("pin after reset", 1'b1, pin_out);
    rd_word(5'h12, 16'h0000);
    rd_word(5'h13, 16'h0000);
    out_en = 1'b1;
    glob = 1'b1;
    for (int p = 0; p < 2; p++) begin
      pol = p[0];
      host.access(1'b1, 5'h13, 16'h0001);
      fire(9);
      hold_low();
      fire(8);
      wait_req(1'b1);
      rd_word(5'h13, 16'h0301);
      wait_req(1'b0);
      glob = 1'b0;
      fire(8);
      hold_low();
      glob = 1'b1;
      wait_req(1'b1);
      rd_word(5'h13, 16'h0101);
      wait_req(1'b0);
      test = 1'b1;
      wait_req(1'b1);
      test = 1'b0;
      wait_req(1'b0);
    end
    out_en = 1'b0;
    host.pd_level = 1'b0;
    repeat (5) @(negedge i_clk);
    chk("pin released", 1'b0, pin_oe);
    chk("power down", 1'b1, pwd);
    host.pd_level = 1'b1;
    repeat (5) @(negedge i_clk);
    chk("power up", 1'b0, pwd);
    chk("reads left", 16'h0000, 16'(exp_q.size()));
    test_done();
  end
endmodule // phy_interrupt_status_enable_tb
